// ### common/rxlat_pkg.sv
// constants for the rapidio address translation windows
`default_nettype none
package rxlat_pkg;
    localparam logic [7:0] reg_ob_base = 8'h00;
    localparam logic [7:0] reg_ob_attr = 8'h04;
    localparam logic [7:0] reg_ob_xlat = 8'h08;
    localparam logic [7:0] reg_ib_base = 8'h0c;
    localparam logic [7:0] reg_ib_attr = 8'h10;
    localparam logic [7:0] reg_ib_xlat = 8'h14;
    localparam logic [7:0] reg_status = 8'h18;
    // lsb-0 positions of msb-0 documented fields
    localparam int base_lo = 0;
    localparam int base_w = 20;
    localparam int ob_ext_lo = 20;
    localparam int ext4_w = 4;
    localparam int ext2_lo = 20;
    localparam int ext2_w = 2;
    localparam int en_bit = 31;
    localparam int prio_lo = 26;
    localparam int pci_bit = 25;
    localparam int seg_lo = 22;
    localparam int sseg_lo = 20;
    localparam int rd_lo = 16;
    localparam int wr_lo = 12;
    localparam int target_interface_lo = 20;
    localparam int size_lo = 0;
    localparam int size_w = 6;
    localparam int tid_lo = 22;
    localparam int ltid_lo = 30;
    localparam int page_bits = 12;
    localparam logic [3:0] kind_nread = 4'h4;
    localparam logic [3:0] kind_nwrite_r = 4'h5;
    localparam logic [3:0] target_interface_local_mem = 4'hf;
    localparam logic [3:0] ib_snoop = 4'h5;
    localparam logic [31:0] reset_zero = 32'h0000_0000;
    typedef enum logic [1:0] {rxlat_idle = 2'b00, rxlat_data = 2'b01} rxlat_state_e;
endpackage : rxlat_pkg
`default_nettype wire

// ### hw/rxlat_top.sv
// outbound and inbound rapidio address translation windows with ahb-lite registers
//
// Summary of operation
// - outbound base: base bits 12-31, extended bits 8-11 give top of 36-bit address
// - outbound attribute bit 0 enables outbound translation
// - flow priority bits 4-5 set request priority; 00 is low
// - attribute bit 6 selects pci ordering; 0 means none
// - segment bits 8-9 and subsegment bits 10-11; 00 gives one window
// - read hit issues read kind from bits 12-15; 0x4 is nread
// - write hit issues write kind from bits 16-19; 0x5 is nwrite_r
// - outbound size bits 26-31 set hit extent; 0x15 is 4 mbyte
// - translation bits 2-9 become destination id of every translated request
// - translation bits 0-1 give target id bits 6-7, large systems only
// - translation bits 12-31 plus extended 10-11 replace window base
// - inbound base holds rapidio start, bits 12-31 plus extended 10-11
// - inbound attribute bit 0 enables inbound translation
// - target interface bits 8-11; 1111 routes to local memory
// - inbound read kind bits 12-15; 0101 is snooping read
// - inbound write kind bits 16-19; 0101 is snooping write
// - inbound size bits 26-31; 0x15 is 4 mbyte
// - inbound translation base bits 12-31, top four bits in 8-11
// - inbound hits map to same offset from translated local base
// - cpu accesses carry at most 32 bits; larger only from dma
`default_nettype none
module rxlat_top #(
    parameter int max_cpu_bytes = 4
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ob_req,
    input wire logic ob_write,
    input wire logic [35:0] ob_addr,
    input wire logic [7:0] ob_bytes,
    input wire logic ob_from_dma,
    output logic ob_pkt_valid,
    output logic ob_pkt_write,
    output logic [3:0] ob_pkt_kind,
    output logic [7:0] ob_pkt_dest_id,
    output logic [1:0] ob_pkt_dest_id_high,
    output logic [1:0] ob_pkt_prio,
    output logic ob_pkt_pci_order,
    output logic [33:0] ob_pkt_addr,
    output logic [7:0] ob_pkt_bytes,
    output logic ob_miss,
    input wire logic ib_req,
    input wire logic ib_write,
    input wire logic [33:0] ib_addr,
    output logic ib_loc_valid,
    output logic ib_loc_write,
    output logic [3:0] ib_loc_kind,
    output logic [3:0] ib_loc_target,
    output logic [35:0] ib_loc_addr,
    output logic ib_miss
);
    typedef struct packed {
        logic [31:0] ob_base;
        logic [31:0] ob_attr;
        logic [31:0] ob_xlat;
        logic [31:0] ib_base;
        logic [31:0] ib_attr;
        logic [31:0] ib_xlat;
        rxlat_pkg::rxlat_state_e st;
        logic [7:0] addr_q;
        logic wr_q;
        logic [31:0] hrdata;
        logic [15:0] ob_hits;
        logic [15:0] ib_hits;
        logic ob_pkt_valid;
        logic ob_pkt_write;
        logic [3:0] ob_pkt_kind;
        logic [7:0] ob_pkt_dest_id;
        logic [1:0] ob_pkt_dest_id_high;
        logic [1:0] ob_pkt_prio;
        logic ob_pkt_pci_order;
        logic [33:0] ob_pkt_addr;
        logic [7:0] ob_pkt_bytes;
        logic ob_miss;
        logic ib_loc_valid;
        logic ib_loc_write;
        logic [3:0] ib_loc_kind;
        logic [3:0] ib_loc_target;
        logic [35:0] ib_loc_addr;
        logic ib_miss;
    } rxlat_state_s;

    rxlat_state_s s_reg;
    rxlat_state_s s_next;

    // window mask from size field: 2^(size+1) bytes, kept within 36 bits
    function automatic logic [35:0] rxlat_mask(input logic [5:0] size);
        logic [6:0] n;
        n = {1'b0, size} + 7'h01;
        if (n >= 7'h24)
            rxlat_mask = {36{1'b1}};
        else
            rxlat_mask = (36'h0_0000_0001 << n[5:0]) - 36'h0_0000_0001;
    endfunction : rxlat_mask

    function automatic logic [31:0] rxlat_field(input logic [31:0] r, input int lo,
                                                input int w);
        rxlat_field = (r >> lo) & ((32'h0000_0001 << w) - 32'h0000_0001);
    endfunction : rxlat_field

    logic [35:0] ob_win_base;
    logic [35:0] ob_win_mask;
    logic [33:0] ob_xl_base;
    logic [35:0] ob_off;
    logic ob_hit;
    logic [33:0] ib_win_base;
    logic [35:0] ib_win_mask;
    logic [35:0] ib_xl_base;
    logic [35:0] ib_off;
    logic ib_hit;
    logic size_ok;
    logic bus_go;

    always_comb
    begin
        ob_win_base = {s_reg.ob_base[rxlat_pkg::ob_ext_lo +: rxlat_pkg::ext4_w],
                       s_reg.ob_base[rxlat_pkg::base_lo +: rxlat_pkg::base_w],
                       12'h000};
        ob_win_mask = rxlat_mask(s_reg.ob_attr[rxlat_pkg::size_lo +: rxlat_pkg::size_w]);
        ob_xl_base = {s_reg.ob_xlat[rxlat_pkg::ext2_lo +: rxlat_pkg::ext2_w],
                      s_reg.ob_xlat[rxlat_pkg::base_lo +: rxlat_pkg::base_w], 12'h000};
        ob_off = ob_addr - ob_win_base;
        ob_hit = s_reg.ob_attr[rxlat_pkg::en_bit] && (ob_addr >= ob_win_base)
                 && ((ob_off & ~ob_win_mask) == 36'h0_0000_0000);
        ib_win_base = {s_reg.ib_base[rxlat_pkg::ext2_lo +: rxlat_pkg::ext2_w],
                       s_reg.ib_base[rxlat_pkg::base_lo +: rxlat_pkg::base_w], 12'h000};
        ib_win_mask = rxlat_mask(s_reg.ib_attr[rxlat_pkg::size_lo +: rxlat_pkg::size_w]);
        ib_xl_base = {s_reg.ib_xlat[rxlat_pkg::ob_ext_lo +: rxlat_pkg::ext4_w],
                      s_reg.ib_xlat[rxlat_pkg::base_lo +: rxlat_pkg::base_w], 12'h000};
        ib_off = {2'b00, ib_addr} - {2'b00, ib_win_base};
        ib_hit = s_reg.ib_attr[rxlat_pkg::en_bit] && (ib_addr >= ib_win_base)
                 && ((ib_off & ~ib_win_mask) == 36'h0_0000_0000);
        size_ok = ob_from_dma || (ob_bytes <= 8'(max_cpu_bytes));
        bus_go = hsel && hready && htrans[1];
    end

    always_comb
    begin
        s_next = s_reg;
        s_next.ob_pkt_valid = 1'b0;
        s_next.ob_miss = 1'b0;
        s_next.ib_loc_valid = 1'b0;
        s_next.ib_miss = 1'b0;
        // register bus: one wait-free data phase
        case (s_reg.st)
            rxlat_pkg::rxlat_idle:
            begin
            end
            rxlat_pkg::rxlat_data:
            begin
                if (s_reg.wr_q)
                begin
                    case (s_reg.addr_q)
                        rxlat_pkg::reg_ob_base: s_next.ob_base = hwdata;
                        rxlat_pkg::reg_ob_attr: s_next.ob_attr = hwdata;
                        rxlat_pkg::reg_ob_xlat: s_next.ob_xlat = hwdata;
                        rxlat_pkg::reg_ib_base: s_next.ib_base = hwdata;
                        rxlat_pkg::reg_ib_attr: s_next.ib_attr = hwdata;
                        rxlat_pkg::reg_ib_xlat: s_next.ib_xlat = hwdata;
                        default: s_next.ob_base = s_reg.ob_base;
                    endcase
                end
            end
            default: s_next.st = rxlat_pkg::rxlat_idle;
        endcase
        s_next.st = bus_go ? rxlat_pkg::rxlat_data : rxlat_pkg::rxlat_idle;
        if (bus_go)
        begin
            s_next.addr_q = {haddr[7:2], 2'b00};
            s_next.wr_q = hwrite;
            case ({haddr[7:2], 2'b00})
                rxlat_pkg::reg_ob_base: s_next.hrdata = s_reg.ob_base;
                rxlat_pkg::reg_ob_attr: s_next.hrdata = s_reg.ob_attr;
                rxlat_pkg::reg_ob_xlat: s_next.hrdata = s_reg.ob_xlat;
                rxlat_pkg::reg_ib_base: s_next.hrdata = s_reg.ib_base;
                rxlat_pkg::reg_ib_attr: s_next.hrdata = s_reg.ib_attr;
                rxlat_pkg::reg_ib_xlat: s_next.hrdata = s_reg.ib_xlat;
                rxlat_pkg::reg_status: s_next.hrdata = {s_reg.ib_hits, s_reg.ob_hits};
                default: s_next.hrdata = rxlat_pkg::reset_zero;
            endcase
        end
        // outbound request translation
        if (ob_req)
        begin
            if (ob_hit && size_ok)
            begin
                s_next.ob_pkt_valid = 1'b1;
                s_next.ob_pkt_write = ob_write;
                s_next.ob_pkt_kind = ob_write
                    ? 4'(rxlat_field(s_reg.ob_attr, rxlat_pkg::wr_lo, 4))
                    : 4'(rxlat_field(s_reg.ob_attr, rxlat_pkg::rd_lo, 4));
                s_next.ob_pkt_dest_id = 8'(rxlat_field(s_reg.ob_xlat, rxlat_pkg::tid_lo, 8));
                s_next.ob_pkt_dest_id_high =
                    2'(rxlat_field(s_reg.ob_xlat, rxlat_pkg::ltid_lo, 2));
                s_next.ob_pkt_prio = 2'(rxlat_field(s_reg.ob_attr, rxlat_pkg::prio_lo, 2));
                s_next.ob_pkt_pci_order = s_reg.ob_attr[rxlat_pkg::pci_bit];
                // only unsegmented windows are handled
                s_next.ob_pkt_addr = ob_xl_base + ob_off[33:0];
                s_next.ob_pkt_bytes = ob_bytes;
                s_next.ob_hits = s_reg.ob_hits + 16'h0001;
            end
            else
                s_next.ob_miss = 1'b1;
        end
        // inbound request translation
        if (ib_req)
        begin
            if (ib_hit)
            begin
                s_next.ib_loc_valid = 1'b1;
                s_next.ib_loc_write = ib_write;
                s_next.ib_loc_kind = ib_write
                    ? 4'(rxlat_field(s_reg.ib_attr, rxlat_pkg::wr_lo, 4))
                    : 4'(rxlat_field(s_reg.ib_attr, rxlat_pkg::rd_lo, 4));
                s_next.ib_loc_target = 4'(rxlat_field(s_reg.ib_attr, rxlat_pkg::target_interface_lo, 4));
                s_next.ib_loc_addr = ib_xl_base + ib_off;
                s_next.ib_hits = s_reg.ib_hits + 16'h0001;
            end
            else
                s_next.ib_miss = 1'b1;
        end
        if (!rstn)
            s_next = '0;
    end

    always_ff @(posedge sys_clk)
    begin
        s_reg <= s_next;
    end

    assign hrdata = s_reg.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ob_pkt_valid = s_reg.ob_pkt_valid;
    assign ob_pkt_write = s_reg.ob_pkt_write;
    assign ob_pkt_kind = s_reg.ob_pkt_kind;
    assign ob_pkt_dest_id = s_reg.ob_pkt_dest_id;
    assign ob_pkt_dest_id_high = s_reg.ob_pkt_dest_id_high;
    assign ob_pkt_prio = s_reg.ob_pkt_prio;
    assign ob_pkt_pci_order = s_reg.ob_pkt_pci_order;
    assign ob_pkt_addr = s_reg.ob_pkt_addr;
    assign ob_pkt_bytes = s_reg.ob_pkt_bytes;
    assign ob_miss = s_reg.ob_miss;
    assign ib_loc_valid = s_reg.ib_loc_valid;
    assign ib_loc_write = s_reg.ib_loc_write;
    assign ib_loc_kind = s_reg.ib_loc_kind;
    assign ib_loc_target = s_reg.ib_loc_target;
    assign ib_loc_addr = s_reg.ib_loc_addr;
    assign ib_miss = s_reg.ib_miss;

    a_ob_disabled: assert property (@(posedge sys_clk) disable iff (!rstn)
        !s_reg.ob_attr[rxlat_pkg::en_bit] && ob_req |=> !ob_pkt_valid && ob_miss)
        else $error("outbound request translated while disabled");
    a_ob_dest: assert property (@(posedge sys_clk) disable iff (!rstn)
        ob_req && ob_hit && size_ok |=>
        ob_pkt_dest_id == $past(s_reg.ob_xlat[rxlat_pkg::tid_lo +: 8]))
        else $error("destination id not from translation register");
    a_ob_hi_id: assert property (@(posedge sys_clk) disable iff (!rstn)
        ob_req && ob_hit && size_ok |=>
        ob_pkt_dest_id_high == $past(s_reg.ob_xlat[rxlat_pkg::ltid_lo +: 2]))
        else $error("high id bits wrong");
    a_ob_kind: assert property (@(posedge sys_clk) disable iff (!rstn)
        ob_req && ob_hit && size_ok && !ob_write |=>
        ob_pkt_kind == $past(s_reg.ob_attr[rxlat_pkg::rd_lo +: 4]))
        else $error("read kind wrong");
    a_ob_wkind: assert property (@(posedge sys_clk) disable iff (!rstn)
        ob_req && ob_hit && size_ok && ob_write |=>
        ob_pkt_kind == $past(s_reg.ob_attr[rxlat_pkg::wr_lo +: 4]))
        else $error("write kind wrong");
    a_ob_prio: assert property (@(posedge sys_clk) disable iff (!rstn)
        ob_pkt_valid |-> ob_pkt_prio == $past(s_reg.ob_attr[rxlat_pkg::prio_lo +: 2]))
        else $error("priority wrong");
    a_cpu_size: assert property (@(posedge sys_clk) disable iff (!rstn)
        ob_req && !ob_from_dma && ob_bytes > 8'(max_cpu_bytes) |=> !ob_pkt_valid)
        else $error("oversized cpu access forwarded");
    a_ib_disabled: assert property (@(posedge sys_clk) disable iff (!rstn)
        ib_req && !s_reg.ib_attr[rxlat_pkg::en_bit] |=> ib_miss && !ib_loc_valid)
        else $error("inbound translated while disabled");
    a_ib_offset: assert property (@(posedge sys_clk) disable iff (!rstn)
        ib_loc_valid |-> (ib_loc_addr & $past(ib_win_mask)) ==
        ({2'b00, $past(ib_addr)} & $past(ib_win_mask)))
        else $error("inbound offset not preserved");
    a_ib_target: assert property (@(posedge sys_clk) disable iff (!rstn)
        ib_loc_valid |-> ib_loc_target == $past(s_reg.ib_attr[rxlat_pkg::target_interface_lo +: 4]))
        else $error("target interface wrong");
    c_ob_read: cover property (@(posedge sys_clk) ob_pkt_valid && !ob_pkt_write);
    c_ob_write: cover property (@(posedge sys_clk) ob_pkt_valid && ob_pkt_write);
    c_ib_hit: cover property (@(posedge sys_clk) ib_loc_valid);
    c_ib_miss: cover property (@(posedge sys_clk) ib_miss);
    c_ob_dma: cover property (@(posedge sys_clk) ob_pkt_valid && ob_pkt_bytes > 8'(max_cpu_bytes));

    // outbound packet fields and answer shape
    a_ob_offset: assert property (@(posedge sys_clk) disable iff (!rstn)
        ob_pkt_valid |-> (ob_pkt_addr & $past(ob_win_mask[33:0])) ==
        ($past(ob_addr[33:0]) & $past(ob_win_mask[33:0])))
        else $error("outbound offset not preserved");
    a_ob_pci: assert property (@(posedge sys_clk) disable iff (!rstn)
        ob_pkt_valid |-> ob_pkt_pci_order == $past(s_reg.ob_attr[rxlat_pkg::pci_bit]))
        else $error("ordering flag wrong");
    a_ob_bytes: assert property (@(posedge sys_clk) disable iff (!rstn)
        ob_pkt_valid |-> ob_pkt_bytes == $past(ob_bytes))
        else $error("payload size wrong");
    a_ob_wflag: assert property (@(posedge sys_clk) disable iff (!rstn)
        ob_pkt_valid |-> ob_pkt_write == $past(ob_write))
        else $error("outbound direction wrong");
    a_ob_answer: assert property (@(posedge sys_clk) disable iff (!rstn)
        ob_req |=> ob_pkt_valid != ob_miss)
        else $error("outbound request not answered once");
    a_ob_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
        !ob_req |=> !ob_pkt_valid && !ob_miss)
        else $error("outbound answer without request");
    a_ob_below: assert property (@(posedge sys_clk) disable iff (!rstn)
        ob_req && ob_addr < ob_win_base |=> ob_miss)
        else $error("access below window base translated");
    // inbound local operation
    a_ib_answer: assert property (@(posedge sys_clk) disable iff (!rstn)
        ib_req |=> ib_loc_valid != ib_miss)
        else $error("inbound request not answered once");
    a_ib_rkind: assert property (@(posedge sys_clk) disable iff (!rstn)
        ib_req && ib_hit && !ib_write |=>
        ib_loc_kind == $past(s_reg.ib_attr[rxlat_pkg::rd_lo +: 4]))
        else $error("inbound read kind wrong");
    a_ib_wkind: assert property (@(posedge sys_clk) disable iff (!rstn)
        ib_req && ib_hit && ib_write |=>
        ib_loc_kind == $past(s_reg.ib_attr[rxlat_pkg::wr_lo +: 4]))
        else $error("inbound write kind wrong");
    a_ib_below: assert property (@(posedge sys_clk) disable iff (!rstn)
        ib_req && ib_addr < ib_win_base |=> ib_miss)
        else $error("inbound access below base translated");
    a_ib_wflag: assert property (@(posedge sys_clk) disable iff (!rstn)
        ib_loc_valid |-> ib_loc_write == $past(ib_write))
        else $error("inbound direction wrong");
endmodule : rxlat_top
`default_nettype wire

// ### testbench/rxlat_remote_model.sv
// remote endpoint model that loops outbound requests back as inbound ones
`default_nettype none
module rxlat_remote_model (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic loop_en,
    input wire logic [3:0] delay,
    input wire logic ob_pkt_valid,
    input wire logic ob_pkt_write,
    input wire logic [33:0] ob_pkt_addr,
    output logic ib_req,
    output logic ib_write,
    output logic [33:0] ib_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    logic [3:0] cnt;
    logic [33:0] held;
    // idle address toggles so a stale value never passes for a request
    always_ff @(posedge sys_clk)
    begin
        ib_req <= 1'h0;
        ib_addr <= ~ib_addr;
        if (!rstn)
        begin
            busy <= 1'h0;
            cnt <= 4'h0;
            ib_write <= 1'h0;
            ib_addr <= 34'h0;
        end
        else if (busy && cnt == 4'h0)
        begin
            ib_req <= 1'h1; // loopback through the switch
            ib_addr <= held;
            busy <= 1'h0;
        end
        else if (busy)
            cnt <= cnt - 4'h1;
        else if (ob_pkt_valid && loop_en)
        begin
            busy <= 1'h1;
            cnt <= delay;
            held <= ob_pkt_addr;
            ib_write <= ob_pkt_write;
        end
    end
endmodule : rxlat_remote_model
`default_nettype wire

// ### testbench/rxlat_top_tb.sv
// self-checking bench for the rapidio address translation windows
`default_nettype none
module rxlat_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] base, attr, xlat;
        logic wr, dma;
        logic [7:0] n;
        logic [35:0] a;
        logic hit;
        logic [33:0] exp;
    } rxlat_row_s;
    typedef struct packed {
        logic [31:0] obx, ibb, iba, ibx;
        logic wr;
        logic [35:0] a;
        logic [3:0] dly;
        logic hit;
        logic [35:0] exp;
    } rxlat_irow_s;
    localparam logic [31:0] wb = 32'h000c6000, wa = 32'h80045015, wx = 32'h00400000;
    localparam logic [31:0] ia = 32'h80f55015, iw = 32'h00001000;
    rxlat_row_s rows [12] = '{
        '{wb, wa, wx, 1'h0, 1'h0, 8'h4, 36'h0c6000010, 1'h1, 34'h10},
        '{wb, wa, wx, 1'h1, 1'h0, 8'h4, 36'h0c63ffffc, 1'h1, 34'h3ffffc},
        '{wb, wa, wx, 1'h1, 1'h0, 8'h4, 36'h0c6400000, 1'h0, 34'h0},
        '{wb, wa, wx, 1'h0, 1'h0, 8'h4, 36'h0c5fffffc, 1'h0, 34'h0},
        '{wb, 32'h00045015, wx, 1'h0, 1'h0, 8'h4, 36'h0c6000000, 1'h0, 34'h0},
        '{wb, 32'h8e045015, 32'haad00400, 1'h0, 1'h0, 8'h4, 36'h0c6123458, 1'h1, 34'h100523458},
        '{wb, wa, wx, 1'h0, 1'h0, 8'h8, 36'h0c6000000, 1'h0, 34'h0},
        '{wb, wa, wx, 1'h1, 1'h1, 8'h40, 36'h0c6000100, 1'h1, 34'h100},
        '{32'h000c8000, 32'h80045016, 32'h00800000, 1'h0, 1'h0, 8'h4, 36'h0c87ffffc, 1'h1, 34'h7ffffc},
        '{32'h000c8000, 32'h80045016, 32'h00800000, 1'h0, 1'h0, 8'h4, 36'h0c8800000, 1'h0, 34'h0},
        '{32'h00fc6000, wa, wx, 1'h0, 1'h0, 8'h4, 36'hfc6000020, 1'h1, 34'h20},
        '{32'h00fc6000, wa, wx, 1'h0, 1'h0, 8'h4, 36'h0c6000020, 1'h0, 34'h0}};
    rxlat_irow_s irows [5] = '{
        '{32'h0, 32'h0, ia, iw, 1'h0, 36'h0c6000abc, 4'h0, 1'h1, 36'h001000abc},
        '{32'h0, 32'h0, ia, iw, 1'h1, 36'h0c63ffffc, 4'h3, 1'h1, 36'h0013ffffc},
        '{32'h0, 32'h0, 32'h00f55015, iw, 1'h0, 36'h0c6000000, 4'h1, 1'h0, 36'h0},
        '{32'h0, 32'h00000400, ia, iw, 1'h1, 36'h0c6000000, 4'h0, 1'h0, 36'h0},
        '{32'h00100000, 32'h00100000, ia, 32'h00301000, 1'h0, 36'h0c6000abc, 4'h2, 1'h1,
            36'h301000abc}};
    logic sys_clk = 1'h0, rstn = 1'h0, hsel = 1'h0, hwrite = 1'h0, loop_en = 1'h0;
    logic ob_req = 1'h0, ob_write = 1'h0, ob_from_dma = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0, ob_pkt_dest_id_high, ob_pkt_prio;
    logic [2:0] hsize = 3'h2;
    logic [35:0] ob_addr = 36'h0, ib_loc_addr;
    logic [7:0] ob_bytes = 8'h0, ob_pkt_dest_id, ob_pkt_bytes;
    logic [33:0] ob_pkt_addr, ib_addr;
    logic [3:0] dly = 4'h0, ob_pkt_kind, ib_loc_kind, ib_loc_target;
    logic hreadyout, hresp, ob_pkt_valid, ob_pkt_write, ob_pkt_pci_order, ob_miss;
    logic ib_req, ib_write, ib_loc_valid, ib_loc_write, ib_miss;
    int n_errors = 0, checks = 0, ob_hits = 0, ib_hits = 0;
    rxlat_top #(.max_cpu_bytes(4)) DUT (
        .sys_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ob_req, .ob_write, .ob_addr,
        .ob_bytes, .ob_from_dma, .ob_pkt_valid, .ob_pkt_write, .ob_pkt_kind, .ob_pkt_dest_id,
        .ob_pkt_dest_id_high, .ob_pkt_prio, .ob_pkt_pci_order, .ob_pkt_addr, .ob_pkt_bytes,
        .ob_miss, .ib_req, .ib_write, .ib_addr, .ib_loc_valid, .ib_loc_write, .ib_loc_kind,
        .ib_loc_target, .ib_loc_addr, .ib_miss);
    rxlat_remote_model far_end (
        .sys_clk, .rstn, .loop_en, .delay(dly), .ob_pkt_valid, .ob_pkt_write, .ob_pkt_addr,
        .ib_req, .ib_write, .ib_addr);
    initial
    begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic give_verdict;
        $display("mismatches %0d, comparisons %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_ready;
        int i;
        i = 0;
        do
        begin
            @(posedge sys_clk);
            i++;
        end
        while (hreadyout !== 1'h1 && i < 20);
        if (hreadyout !== 1'h1)
        begin
            n_errors++;
            give_verdict();
        end
    endtask : wait_ready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge sys_clk);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask : bus
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'h1, a, d, q);
    endtask : wreg
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'h0, a, 32'h0, q);
        chk(q, e);
        chk(hresp, 1'h0);
        chk(hreadyout, 1'h1);
    endtask : rchk
    task automatic ob_op(input logic wr, input logic dma, input logic [7:0] n,
        input logic [35:0] a);
        @(posedge sys_clk);
        ob_req <= 1'h1;
        ob_write <= wr;
        ob_from_dma <= dma;
        ob_bytes <= n;
        ob_addr <= a;
        @(posedge sys_clk);
        ob_req <= 1'h0;
        // answer stands for one cycle: look at it mid-cycle
        @(negedge sys_clk);
    endtask : ob_op
    initial
    begin
        int k;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'h1;
        for (k = 0; k < 8; k++)
            rchk(8'(k * 4), 32'h0);
        for (k = 0; k < 7; k++)
            wreg(8'(k * 4 + 4), 32'h5a5a0000 | 32'(k));
        for (k = 0; k < 5; k++)
            rchk(8'(k * 4 + 4), 32'h5a5a0000 | 32'(k));
        rchk(8'h1c, 32'h0);
        foreach (rows[i])
        begin
            wreg(rxlat_pkg::reg_ob_attr, 32'h0);
            wreg(rxlat_pkg::reg_ob_base, rows[i].base);
            wreg(rxlat_pkg::reg_ob_xlat, rows[i].xlat);
            wreg(rxlat_pkg::reg_ob_attr, rows[i].attr);
            ob_op(rows[i].wr, rows[i].dma, rows[i].n, rows[i].a);
            chk(ob_pkt_valid, rows[i].hit);
            chk(ob_miss, !rows[i].hit);
            if (rows[i].hit)
            begin
                ob_hits++;
                chk(ob_pkt_addr, rows[i].exp);
                chk(ob_pkt_dest_id, rows[i].xlat[29:22]);
                chk(ob_pkt_dest_id_high, rows[i].xlat[31:30]);
                chk(ob_pkt_prio, rows[i].attr[27:26]);
                chk(ob_pkt_pci_order, rows[i].attr[25]);
                chk(ob_pkt_kind,
                    rows[i].wr ? rows[i].attr[15:12] : rows[i].attr[19:16]);
                chk(ob_pkt_write, rows[i].wr);
                chk(ob_pkt_bytes, rows[i].n);
            end
        end
        wreg(rxlat_pkg::reg_ob_attr, 32'h0);
        wreg(rxlat_pkg::reg_ob_base, wb);
        loop_en <= 1'h1;
        foreach (irows[i])
        begin
            wreg(rxlat_pkg::reg_ob_attr, 32'h0);
            wreg(rxlat_pkg::reg_ib_attr, 32'h0);
            wreg(rxlat_pkg::reg_ob_xlat, irows[i].obx);
            wreg(rxlat_pkg::reg_ib_base, irows[i].ibb);
            wreg(rxlat_pkg::reg_ib_xlat, irows[i].ibx);
            wreg(rxlat_pkg::reg_ob_attr, wa);
            wreg(rxlat_pkg::reg_ib_attr, irows[i].iba);
            dly <= irows[i].dly;
            ob_op(irows[i].wr, 1'h0, 8'h4, irows[i].a);
            chk(ob_pkt_valid, 1'h1);
            ob_hits++;
            for (k = 0; k < 30 && ib_loc_valid !== 1'h1 && ib_miss !== 1'h1; k++)
                @(negedge sys_clk);
            if (k == 30)
            begin
                n_errors++;
                give_verdict();
            end
            chk(ib_loc_valid, irows[i].hit);
            chk(ib_miss, !irows[i].hit);
            if (irows[i].hit)
            begin
                ib_hits++;
                chk(ib_loc_addr, irows[i].exp);
                chk(ib_loc_target, irows[i].iba[23:20]);
                chk(ib_loc_kind,
                    irows[i].wr ? irows[i].iba[15:12] : irows[i].iba[19:16]);
                chk(ib_loc_write, irows[i].wr);
            end
        end
        wreg(rxlat_pkg::reg_status, 32'hffffffff);
        rchk(rxlat_pkg::reg_status, {16'(ib_hits), 16'(ob_hits)});
        rstn <= 1'h0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'h1;
        rchk(rxlat_pkg::reg_ob_attr, 32'h0);
        ob_op(1'h0, 1'h0, 8'h4, 36'h0c6000000);
        chk(ob_miss, 1'h1);
        give_verdict();
    end
endmodule : rxlat_top_tb
`default_nettype wire
